//--- src/stp_system_timing.sv
// System timing prescalers: instruction cycle, microsecond, millisecond and 100 ms time bases
// Operation
// - Instruction cycle is four system clocks
// - No twelve-clock instruction cycle option
// - Instructions take one, two or four cycles
// - One system clock drives all timing
// - Microsecond tick divides by register plus one
// - Microsecond tick feeds flash write, PWM
// - Millisecond tick divides by 16-bit value plus one
// - Millisecond tick feeds erase, interrupts, watchdog
// - Both ticks usable as auxiliary interrupt sources
// - Speed select clear picks microsecond PWM clock
// - PWM divides microsecond tick, or raw clock when speed select is set, by period registers plus one
// - Flash write period is microsecond_prescaler times 5(field+1)
// - 100 ms base counts value plus one ms
`timescale 1ns/1ps
module stp_system_timing (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire stp_pkg::stp_sfr_addr_t sfr_addr,
  input wire stp_pkg::stp_sfr_data_t sfr_wdata,
  input wire stp_pkg::stp_instr_len_t instr_len,
  output stp_pkg::stp_sfr_data_t sfr_rdata,
  output logic sfr_hit,
  output logic instr_cycle,
  output logic instr_done,
  output logic microsecond_prescaler_tick,
  output logic msec_tick,
  output logic hms_tick,
  output logic pwm_clk_tick,
  output logic flash_write_tick,
  output logic microsecond_prescaler_aux_event,
  output logic msec_aux_event
);
  import stp_pkg::*;
  `include "stp_consts.svh"

  logic [7:0] microsecond_prescaler_q;
  logic [7:0] microsecond_prescaler_d;
  logic [15:0] msec_q;
  logic [15:0] msec_d;
  logic [7:0] hms_q;
  logic [7:0] hms_d;
  logic [3:0] ftm_q;
  logic [3:0] ftm_d;
  logic [7:0] pwm_control_q;
  logic [7:0] pwm_control_d;
  logic [15:0] pwmper_q;
  logic [15:0] pwmper_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit_q;
  logic hit_d;
  logic microsecond_prescaler_t;
  logic msec_t;
  logic hms_t;
  logic pwm_t;
  logic fw_t;
  logic [6:0] fw_limit;
  logic pwm_src;
  logic [5:0] out_d;
  logic [5:0] out_q;

  // Register writes steer every divider limit
  always_comb
  begin
    microsecond_prescaler_d = microsecond_prescaler_q;
    msec_d = msec_q;
    hms_d = hms_q;
    ftm_d = ftm_q;
    pwm_control_d = pwm_control_q;
    pwmper_d = pwmper_q;
    if (sfr_wr)
    begin
      unique case (sfr_addr)
        `STP_ADDR_MICROSECOND_PRESCALER_PRESCALER: microsecond_prescaler_d = sfr_wdata;
        `STP_ADDR_MSEC_LOW: msec_d[7:0] = sfr_wdata;
        `STP_ADDR_MSEC_HIGH: msec_d[15:8] = sfr_wdata;
        `STP_ADDR_HUNDRED_MS_PRESCALER: hms_d = sfr_wdata;
        `STP_ADDR_FLASH_TIMING: ftm_d = sfr_wdata[`STP_FLASH_TIMING_MSB:`STP_FLASH_TIMING_LSB];
        `STP_ADDR_PWM_CONTROL: pwm_control_d = sfr_wdata;
        `STP_ADDR_PWM_PERIOD_LOW: pwmper_d[7:0] = sfr_wdata;
        `STP_ADDR_PWM_PERIOD_HIGH: pwmper_d[15:8] = sfr_wdata;
        default: ;
      endcase
    end
  end

  // Read data is registered, so it appears one clock after the strobe
  always_comb
  begin
    rdata_d = 8'h00;
    hit_d = 1'b1;
    unique case (sfr_addr)
      `STP_ADDR_MICROSECOND_PRESCALER_PRESCALER: rdata_d = microsecond_prescaler_q;
      `STP_ADDR_MSEC_LOW: rdata_d = msec_q[7:0];
      `STP_ADDR_MSEC_HIGH: rdata_d = msec_q[15:8];
      `STP_ADDR_HUNDRED_MS_PRESCALER: rdata_d = hms_q;
      `STP_ADDR_FLASH_TIMING: rdata_d = {4'h0, ftm_q};
      `STP_ADDR_PWM_CONTROL: rdata_d = pwm_control_q;
      `STP_ADDR_PWM_PERIOD_LOW: rdata_d = pwmper_q[7:0];
      `STP_ADDR_PWM_PERIOD_HIGH: rdata_d = pwmper_q[15:8];
      default: hit_d = 1'b0;
    endcase
    if (!sfr_rd)
    begin
      rdata_d = rdata_q;
      hit_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      microsecond_prescaler_q <= `STP_RST_MICROSECOND_PRESCALER;
      msec_q <= `STP_RST_MSEC;
      hms_q <= `STP_RST_HUNDRED_MS_PRESCALER;
      ftm_q <= `STP_RST_FLASH_TIMING;
      pwm_control_q <= `STP_RST_PWM_CONTROL;
      pwmper_q <= `STP_RST_PWM_PERIOD;
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end
    else if (ce)
    begin
      microsecond_prescaler_q <= microsecond_prescaler_d;
      msec_q <= msec_d;
      hms_q <= hms_d;
      ftm_q <= ftm_d;
      pwm_control_q <= pwm_control_d;
      pwmper_q <= pwmper_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  stp_instr_timer u_instr (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .instr_len(instr_len),
    .instr_cycle(instr_cycle),
    .instr_done(instr_done)
  );

  // All dividers run on clk alone
  stp_divider #(.WIDTH(8)) u_microsecond_prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .step(1'b1),
    .limit(microsecond_prescaler_q),
    .tick(microsecond_prescaler_t)
  );

  stp_divider #(.WIDTH(16)) u_msec (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .step(1'b1),
    .limit(msec_q),
    .tick(msec_t)
  );

  stp_divider #(.WIDTH(8)) u_hms (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .step(msec_t),
    .limit(hms_q),
    .tick(hms_t)
  );

  // Speed select set leaves the PWM on the raw clock
  assign pwm_src = pwm_control_q[`STP_PWM_SPEED_SELECT_BIT] ? 1'b1 : microsecond_prescaler_t;

  stp_divider #(.WIDTH(16)) u_pwm (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .step(pwm_src),
    .limit(pwmper_q),
    .tick(pwm_t)
  );

  // Field 0..15 gives 5..80 microsecond_prescaler ticks; 30-40 us is software's job
  assign fw_limit = 7'(({3'b000, ftm_q} + 7'd1) * 7'(`STP_FLASH_WRITE_MULT) - 7'd1);

  stp_divider #(.WIDTH(7)) u_fw (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .step(microsecond_prescaler_t),
    .limit(fw_limit),
    .tick(fw_t)
  );

  always_comb
  begin
    out_d = {microsecond_prescaler_t, msec_t, hms_t, pwm_t, fw_t, microsecond_prescaler_t};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_q <= 6'h00;
    end
    else if (ce)
    begin
      out_q <= out_d;
    end
  end

  assign microsecond_prescaler_tick = out_q[5];
  assign msec_tick = out_q[4];
  assign hms_tick = out_q[3];
  assign pwm_clk_tick = out_q[2];
  assign flash_write_tick = out_q[1];
  assign microsecond_prescaler_aux_event = out_q[0];
  assign msec_aux_event = out_q[4];
  assign sfr_rdata = rdata_q;
  assign sfr_hit = hit_q;

  // Helper counter of clocks between microsecond ticks
  // A rewritten limit, or reset, spoils the period in flight, so that period is not judged
  logic [8:0] gap_q;
  logic microsecond_prescaler_dirty_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_q <= 9'h000;
      microsecond_prescaler_dirty_q <= 1'b1;
    end
    else if (ce)
    begin
      gap_q <= microsecond_prescaler_t ? 9'h000 : 9'(gap_q + 9'h001);
      if (microsecond_prescaler_d != microsecond_prescaler_q)
      begin
        microsecond_prescaler_dirty_q <= 1'b1;
      end
      else if (microsecond_prescaler_t)
      begin
        microsecond_prescaler_dirty_q <= 1'b0;
      end
    end
  end

  property p_instr_period;
    @(posedge clk) disable iff (!rst_b) (ce && instr_cycle) |-> ##1 !instr_cycle;
  endproperty
  a_instr_period: assert property (p_instr_period) else $error("instruction cycle too short");

  property p_instr_every4;
    @(posedge clk) disable iff (!rst_b) ce[*5] |-> (instr_cycle || $past(instr_cycle) ||
      $past(instr_cycle, 2) || $past(instr_cycle, 3));
  endproperty
  a_instr_every4: assert property (p_instr_every4) else $error("instruction cycle missing");

  property p_microsecond_prescaler_period;
    @(posedge clk) disable iff (!rst_b)
      (ce && microsecond_prescaler_t && $stable(microsecond_prescaler_q) && !microsecond_prescaler_dirty_q && gap_q > 9'h000)
      |-> gap_q == {1'b0, microsecond_prescaler_q};
  endproperty
  a_microsecond_prescaler_period: assert property (p_microsecond_prescaler_period) else $error("microsecond tick period wrong");

  property p_microsecond_prescaler_out;
    @(posedge clk) disable iff (!rst_b) (ce && microsecond_prescaler_t) |=> microsecond_prescaler_tick && microsecond_prescaler_aux_event;
  endproperty
  a_microsecond_prescaler_out: assert property (p_microsecond_prescaler_out) else $error("microsecond tick not forwarded");

  property p_msec_out;
    @(posedge clk) disable iff (!rst_b) (ce && msec_t) |=> msec_tick && msec_aux_event;
  endproperty
  a_msec_out: assert property (p_msec_out) else $error("millisecond tick not forwarded");

  property p_hms_src;
    @(posedge clk) disable iff (!rst_b) (ce && $past(ce) && hms_t) |-> $past(msec_t);
  endproperty
  a_hms_src: assert property (p_hms_src) else $error("100 ms tick without ms tick");

  property p_pwm_src;
    @(posedge clk) disable iff (!rst_b)
      (ce && $past(ce) && pwm_t && !$past(pwm_control_q[`STP_PWM_SPEED_SELECT_BIT])) |-> $past(microsecond_prescaler_t);
  endproperty
  a_pwm_src: assert property (p_pwm_src) else $error("pwm tick without microsecond_prescaler tick");

  property p_fw_src;
    @(posedge clk) disable iff (!rst_b) (ce && $past(ce) && fw_t) |-> $past(microsecond_prescaler_t);
  endproperty
  a_fw_src: assert property (p_fw_src) else $error("flash write tick without microsecond_prescaler tick");

  property p_done_on_cycle;
    @(posedge clk) disable iff (!rst_b) instr_done |-> instr_cycle;
  endproperty
  a_done_on_cycle: assert property (p_done_on_cycle) else $error("instruction end off a cycle boundary");

  c_microsecond_prescaler: cover property (@(posedge clk) disable iff (!rst_b) microsecond_prescaler_tick);
  c_msec: cover property (@(posedge clk) disable iff (!rst_b) msec_tick);
  c_pwm: cover property (@(posedge clk) disable iff (!rst_b) pwm_clk_tick);
  c_fw: cover property (@(posedge clk) disable iff (!rst_b) flash_write_tick);
endmodule

//--- src/stp_consts.svh
// Register offsets, field positions and timing counts of the system timing prescalers
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH
`define STP_ADDR_MICROSECOND_PRESCALER_PRESCALER 8'hFB
`define STP_ADDR_MSEC_LOW 8'hFC
`define STP_ADDR_MSEC_HIGH 8'hFD
`define STP_ADDR_HUNDRED_MS_PRESCALER 8'hFE
`define STP_ADDR_FLASH_TIMING 8'hEF
`define STP_ADDR_PWM_CONTROL 8'hA1
`define STP_ADDR_PWM_PERIOD_LOW 8'hA2
`define STP_ADDR_PWM_PERIOD_HIGH 8'hA3
`define STP_PWM_SPEED_SELECT_BIT 3
`define STP_FLASH_TIMING_MSB 3
`define STP_FLASH_TIMING_LSB 0
`define STP_FLASH_WRITE_MULT 5
`define STP_CLKS_PER_INSTR 4
`define STP_RST_MICROSECOND_PRESCALER 8'h0B
`define STP_RST_MSEC 16'h2EDF
`define STP_RST_HUNDRED_MS_PRESCALER 8'h63
`define STP_RST_FLASH_TIMING 4'h6
`define STP_RST_PWM_CONTROL 8'h00
`define STP_RST_PWM_PERIOD 16'h0000
`endif

//--- src/stp_pkg.sv
// Types shared by the system timing prescaler design
package stp_pkg;
  typedef enum logic [1:0] {
    STP_INSTR_ONE,
    STP_INSTR_TWO,
    STP_INSTR_FOUR
  } stp_instr_len_t;
  typedef logic [7:0] stp_sfr_addr_t;
  typedef logic [7:0] stp_sfr_data_t;
endpackage

//--- src/stp_divider.sv
// Programmable modulo counter emitting a one-clock tick every value+1 input events
`timescale 1ns/1ps
module stp_divider #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic step,
  input wire logic [WIDTH-1:0] limit,
  output logic tick
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (step)
    begin
      // A limit lowered below the count wraps at once, never runs away
      if (cnt_q >= limit)
      begin
        cnt_d = '0;
        tick_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

//--- src/stp_instr_timer.sv
// Fixed four-clock instruction cycle sequencer and instruction length counter
`timescale 1ns/1ps
module stp_instr_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire stp_pkg::stp_instr_len_t instr_len,
  output logic instr_cycle,
  output logic instr_done
);
  import stp_pkg::*;
  `include "stp_consts.svh"
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [1:0] left_q;
  logic [1:0] left_d;
  logic cyc_q;
  logic cyc_d;
  logic done_q;
  logic done_d;
  logic [1:0] need;

  always_comb
  begin
    unique case (instr_len)
      STP_INSTR_ONE: need = 2'd0;
      STP_INSTR_TWO: need = 2'd1;
      STP_INSTR_FOUR: need = 2'd3;
      default: need = 2'd0;
    endcase
    // No strap or register alters this ratio
    phase_d = 2'(phase_q + 2'd1);
    cyc_d = (phase_q == 2'(`STP_CLKS_PER_INSTR - 1));
    left_d = left_q;
    done_d = 1'b0;
    if (cyc_d)
    begin
      if (left_q == 2'd0)
      begin
        done_d = 1'b1;
        left_d = need;
      end
      else
      begin
        left_d = 2'(left_q - 2'd1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q <= 2'd0;
      left_q <= 2'd0;
      cyc_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      phase_q <= phase_d;
      left_q <= left_d;
      cyc_q <= cyc_d;
      done_q <= done_d;
    end
  end

  assign instr_cycle = cyc_q;
  assign instr_done = done_q;
endmodule

//--- tb/stp_system_timing_tb_top.sv
// Self-checking testbench for the system timing prescalers
`timescale 1ns/1ps
`include "stp_consts.svh"
module stp_system_timing_tb_top;
  import stp_pkg::*;
  logic clk;
  logic rst_b;
  logic ce;
  logic sfr_wr;
  logic sfr_rd;
  stp_sfr_addr_t sfr_addr;
  stp_sfr_data_t sfr_wdata;
  stp_instr_len_t instr_len;
  stp_sfr_data_t sfr_rdata;
  logic sfr_hit, instr_cycle, instr_done, microsecond_prescaler_tick, msec_tick, hms_tick;
  logic pwm_clk_tick, flash_write_tick, microsecond_prescaler_aux_event, msec_aux_event;
  logic [31:0] seed = 32'h6A100E37;
  int n_errors = 0;
  int compares = 0;
  int u, m, h, f, p, spd, chg;
  logic last;

  stp_system_timing stp_system_timing_inst (
    .clk(clk), .rst_b(rst_b), .ce(ce), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .instr_len(instr_len),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .instr_cycle(instr_cycle),
    .instr_done(instr_done), .microsecond_prescaler_tick(microsecond_prescaler_tick), .msec_tick(msec_tick),
    .hms_tick(hms_tick), .pwm_clk_tick(pwm_clk_tick), .flash_write_tick(flash_write_tick),
    .microsecond_prescaler_aux_event(microsecond_prescaler_aux_event), .msec_aux_event(msec_aux_event)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int exp_pwm(input int us, input int per, input int fast);
    return fast ? per + 1 : (per + 1) * (us + 1);
  endfunction

  function automatic int exp_flash(input int us, input int fld);
    return (fld + 1) * 5 * (us + 1);
  endfunction

  function automatic int exp_hms(input int ms, input int hm);
    return (hm + 1) * (ms + 1);
  endfunction

  function automatic logic sig(input int s);
    case (s)
      0: return microsecond_prescaler_tick;
      1: return msec_tick;
      2: return hms_tick;
      3: return pwm_clk_tick;
      4: return flash_write_tick;
      5: return instr_cycle;
      default: return instr_done;
    endcase
  endfunction

  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc;
    sfr_wr = 1'b0;
    cyc;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask, input logic hit);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc;
    sfr_rd = 1'b0;
    check({8'h00, sfr_rdata & mask}, {8'h00, exp}, $sformatf("read %0h", a));
    check({15'h0000, sfr_hit}, {15'h0000, hit}, $sformatf("hit %0h", a));
    cyc;
  endtask

  // Skips two pulses so a period cut short by reprogramming is never measured
  task automatic measure(input int s, input int exp);
    int k;
    int n;
    n = 0;
    k = 0;
    while (n < 2 && k < 20000)
    begin
      cyc;
      k++;
      if (sig(s) === 1'b1) n++;
    end
    k = 0;
    do
    begin
      cyc;
      k++;
    end while (sig(s) !== 1'b1 && k < 5000);
    check(k[15:0], exp[15:0], $sformatf("period of output %0d", s));
    if (s == 0) check({15'h0000, microsecond_prescaler_aux_event}, 16'h0001, "microsecond_prescaler aux");
    if (s == 1) check({15'h0000, msec_aux_event}, 16'h0001, "msec aux");
  endtask

  initial
  begin
    #900000;
    n_errors++;
    give_verdict;
  end

  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    instr_len = STP_INSTR_ONE;
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    rd_check(`STP_ADDR_MICROSECOND_PRESCALER_PRESCALER, 8'h0B, 8'hFF, 1'b1);
    rd_check(`STP_ADDR_MSEC_LOW, 8'hDF, 8'hFF, 1'b1);
    rd_check(`STP_ADDR_MSEC_HIGH, 8'h2E, 8'hFF, 1'b1);
    rd_check(`STP_ADDR_HUNDRED_MS_PRESCALER, 8'h63, 8'hFF, 1'b1);
    rd_check(`STP_ADDR_FLASH_TIMING, 8'h06, 8'h0F, 1'b1);
    wr_reg(8'h10, 8'h5A);
    rd_check(8'h10, 8'h00, 8'hFF, 1'b0);
    measure(5, 4);
    for (int i = 0; i < 3; i++)
    begin
      instr_len = stp_instr_len_t'(i);
      measure(6, 4 << i);
    end
    // Round zero is the all-zero corner where every divider but flash write (every fifth step) ticks each step
    for (int r = 0; r < 5; r++)
    begin
      u = (r == 0) ? 0 : 1 + rnd() % 6;
      m = (r == 0) ? 0 : 2 + rnd() % 300;
      h = (r == 0) ? 0 : rnd() % 4;
      f = (r == 0) ? 0 : rnd() % 4;
      p = (r == 0) ? 0 : rnd() % 4;
      spd = r % 2;
      wr_reg(`STP_ADDR_MICROSECOND_PRESCALER_PRESCALER, u[7:0]);
      wr_reg(`STP_ADDR_MSEC_LOW, m[7:0]);
      wr_reg(`STP_ADDR_MSEC_HIGH, m[15:8]);
      wr_reg(`STP_ADDR_HUNDRED_MS_PRESCALER, h[7:0]);
      wr_reg(`STP_ADDR_FLASH_TIMING, f[7:0]);
      wr_reg(`STP_ADDR_PWM_CONTROL, spd ? 8'h08 : 8'h00);
      wr_reg(`STP_ADDR_PWM_PERIOD_LOW, p[7:0]);
      wr_reg(`STP_ADDR_PWM_PERIOD_HIGH, 8'h00);
      rd_check(`STP_ADDR_MICROSECOND_PRESCALER_PRESCALER, u[7:0], 8'hFF, 1'b1);
      rd_check(`STP_ADDR_MSEC_LOW, m[7:0], 8'hFF, 1'b1);
      rd_check(`STP_ADDR_MSEC_HIGH, m[15:8], 8'hFF, 1'b1);
      measure(0, u + 1);
      measure(1, m + 1);
      measure(2, exp_hms(m, h));
      measure(3, exp_pwm(u, p, spd));
      measure(4, exp_flash(u, f));
    end
    // Software keeps the flash write clock at 35 us: one microsecond is 100 clocks here
    wr_reg(`STP_ADDR_MICROSECOND_PRESCALER_PRESCALER, 8'h63);
    wr_reg(`STP_ADDR_FLASH_TIMING, 8'h06);
    measure(4, exp_flash(99, 6));
    // A frozen clock enable must stop the alternating period-two tick
    wr_reg(`STP_ADDR_MICROSECOND_PRESCALER_PRESCALER, 8'h01);
    measure(0, 2);
    ce = 1'b0;
    chg = 0;
    last = microsecond_prescaler_tick;
    repeat (40)
    begin
      cyc;
      if (microsecond_prescaler_tick !== last) chg++;
    end
    check(chg[15:0], 16'h0000, "ticks while frozen");
    ce = 1'b1;
    measure(0, 2);
    give_verdict;
  end
endmodule
